/* core/rtcit_defines.svh */
// Constants for the clock control and interrupt timer block
`ifndef RTCIT_DEFINES_SVH
`define RTCIT_DEFINES_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RTCIT_CLK_PERIOD_NS   100
`define RTCIT_TICK_PERIOD_NS  100000000
`define RTCIT_TICK_CYCLES     (`RTCIT_TICK_PERIOD_NS / `RTCIT_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define RTCIT_ADDR_CTRL       4'h0
`define RTCIT_ADDR_SHARED     4'hf

// ----------------------------------------------------------------
// Control write latches and status read bits
// ----------------------------------------------------------------
`define RTCIT_CW_TEST         3
`define RTCIT_CW_CLK_HALT     2
`define RTCIT_CW_INT_SEL      1
`define RTCIT_CW_INT_HALT     0
`define RTCIT_CR_DCF          3
`define RTCIT_CR_INT_FLAG     0

// ----------------------------------------------------------------
// Clock setting and interrupt register fields
// ----------------------------------------------------------------
`define RTCIT_CS_LEAP_HI      3
`define RTCIT_CS_LEAP_LO      2
`define RTCIT_CS_AMPM         1
`define RTCIT_CS_MODE24       0
`define RTCIT_IR_REPEAT       3
`define RTCIT_IR_PER_HI       2

// ----------------------------------------------------------------
// Reset values and period codes, in 100 ms ticks
// ----------------------------------------------------------------
`define RTCIT_CTRL_RESET      4'h1
`define RTCIT_CSET_RESET      4'h0
`define RTCIT_IREG_RESET      4'h0
`define RTCIT_PER_NONE        3'h0
`define RTCIT_TICKS_0P1       10'h001
`define RTCIT_TICKS_0P5       10'h005
`define RTCIT_TICKS_1         10'h00a
`define RTCIT_TICKS_5         10'h032
`define RTCIT_TICKS_10        10'h064
`define RTCIT_TICKS_30        10'h12c
`define RTCIT_TICKS_60        10'h258

`endif

/* core/rtcit_pkg.sv */
// Types shared by the clock control and interrupt timer block
package rtcit_pkg;

  // Raw parallel bus pins, all active low strobes
  typedef struct packed {
    logic       cs_n;   // Chip select
    logic       rd_n;   // Read strobe
    logic       wr_n;   // Write strobe
    logic [3:0] addr;   // Register address
    logic [3:0] data;   // Write data
  } rtcit_pins_t;

  // Four write-only control latches
  typedef struct packed {
    logic test;         // Test mode
    logic clk_halt;     // Clock start/stop
    logic int_sel;      // Address 15 select
    logic int_halt;     // Interrupt start/stop
  } rtcit_ctrl_t;

  // Bus access phase
  typedef enum logic [1:0] {
    RTCIT_IDLE,
    RTCIT_READ,
    RTCIT_WRITE
  } rtcit_phase_t;

endpackage : rtcit_pkg

/* core/rtcit_core.sv */
// Control register, clock setting register and interrupt timer
`timescale 1ns/10ps
`include "rtcit_defines.svh"

// ----------------------------------------------------------------
// Functional notes
// - Address 15 selected by control bit 1
// - Timing independent of address 15 selection
// - Clock setting: leap 3:2, AM/PM 1, mode 0
// - Leap counter increments at year rollover
// - AM/PM toggles at noon, zero in 24h
// - Mode bit 0 twelve-hour, 1 twenty-four
// - Low three bits select interrupt period
// - Bit 3 selects single or repeated
// - Period zero clears output, sets halt
// - Repeat timeouts aligned, no accumulated error
// - Address 0 split write latches, read flags
// - Latches: test, clock halt, select, int halt
// - Test latch enters and leaves test mode
// - Clock halt stops time, zeroes tenths
// - Interrupt halt resets timer; zero restarts
// - Single mode stops after timeout
// - Repeated mode runs without processor action
// - Read: changed flag bit 3, irq bit 0
// - Changed flag set by tick, cleared by read
// - Timeout sets flag, drives irq low
// - Flags cleared at read strobe trailing edge
// - Timeout during read deferred until read ends
// - Tick during control read ignored
// ----------------------------------------------------------------
module rtcit_core
  import rtcit_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `RTCIT_TICK_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire rtcit_pins_t pins,
  input  wire logic        year_roll,
  input  wire logic        noon_roll,
  output logic [3:0]       data_out,
  output logic             data_oe,
  output logic             irq_out,
  output logic             irq_oe,
  output logic             setting_tick,
  output logic             tenths_clear,
  output logic             test_mode,
  output logic             hour_mode_24
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int PW = $bits(rtcit_pins_t);

  logic [PW-1:0] sync1;          // First synchroniser stage
  logic [PW-1:0] sync2;          // Second stage
  logic [PW-1:0] sync3;          // Third stage
  rtcit_pins_t   pin_f;          // Filtered pin image
  rtcit_phase_t  phase;          // Current bus access phase
  rtcit_phase_t  next_phase;     // Phase decoded from filtered pins
  logic [3:0]    acc_addr;       // Address held through the access
  logic          rd_end;         // Trailing edge of any read
  logic          wr_end;         // Trailing edge of any write
  logic          ctrl_rd;        // Control register read in progress
  logic          ctrl_rd_end;    // Trailing edge of control read
  logic          ctrl_wr;        // Write commit to address 0
  logic          shared_wr;      // Write commit to address 15
  rtcit_ctrl_t   ctrl;           // Control write latches
  logic [1:0]    leap;           // Leap year counter
  logic          ampm;           // AM/PM indicator
  logic [3:0]    ireg;           // Interrupt register
  logic [31:0]   div_cnt;        // Tick divider
  logic          tick;           // One-cycle 100 ms tick
  logic [9:0]    tmr_cnt;        // Interrupt timer count
  logic [9:0]    tmr_limit;      // Ticks per period
  logic          timeout;        // One-cycle timer expiry
  logic          to_pend;        // Expiry stored during control read
  logic          dcf;            // Data-changed flag
  logic          int_flag;       // Interrupt flag
  logic          irq_act;        // Interrupt output asserted
  logic [3:0]    next_rdata;     // Read mux
  logic          osc_toggle;     // Test mode square wave

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Three stages; a change is accepted only when stages 2 and 3 agree
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sync1 <= '1;
      sync2 <= '1;
      sync3 <= '1;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Per-bit acceptance filter, idle state is all ones (strobes high)
  genvar gi;
  generate
    for (gi = 0; gi < PW; gi++) begin : g_filt
      logic bit_f;  // Accepted level of this pin
      always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
          bit_f <= 1'b1;
        end else if (sync2[gi] == sync3[gi]) begin
          bit_f <= sync3[gi];
        end
      end
      assign pin_f[gi] = bit_f;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Bus access decode
  // ----------------------------------------------------------------
  // Phase from filtered strobes; read wins if both are low
  always_comb begin
    if (pin_f.cs_n) begin
      next_phase = RTCIT_IDLE;
    end else if (!pin_f.rd_n) begin
      next_phase = RTCIT_READ;
    end else if (!pin_f.wr_n) begin
      next_phase = RTCIT_WRITE;
    end else begin
      next_phase = RTCIT_IDLE;
    end
  end

  // Phase register and address captured at access start
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      phase    <= RTCIT_IDLE;
      acc_addr <= 4'h0;
    end else begin
      phase <= next_phase;
      if (phase == RTCIT_IDLE) begin
        acc_addr <= pin_f.addr;
      end
    end
  end

  // Strobe events; a control read counts from its first edge, so a
  // timeout landing on that edge is deferred rather than lost
  always_comb begin
    rd_end      = (phase == RTCIT_READ) && (next_phase != RTCIT_READ);
    wr_end      = (phase == RTCIT_WRITE) && (next_phase != RTCIT_WRITE);
    ctrl_rd     = (phase == RTCIT_READ) ?
                  (acc_addr == `RTCIT_ADDR_CTRL) :
                  (next_phase == RTCIT_READ &&
                   pin_f.addr == `RTCIT_ADDR_CTRL);
    ctrl_rd_end = rd_end && (acc_addr == `RTCIT_ADDR_CTRL);
    ctrl_wr     = wr_end && (acc_addr == `RTCIT_ADDR_CTRL);
    shared_wr   = wr_end && (acc_addr == `RTCIT_ADDR_SHARED);
  end

  // ----------------------------------------------------------------
  // Control write latches
  // ----------------------------------------------------------------
  // Data is taken at the write trailing edge, like a latch closing
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ctrl <= `RTCIT_CTRL_RESET;
    end else begin
      if (ctrl_wr) begin
        ctrl.test     <= pin_f.data[`RTCIT_CW_TEST];
        ctrl.clk_halt <= pin_f.data[`RTCIT_CW_CLK_HALT];
        ctrl.int_sel  <= pin_f.data[`RTCIT_CW_INT_SEL];
        ctrl.int_halt <= pin_f.data[`RTCIT_CW_INT_HALT];
      end
      // Zero period forces the halt latch, over any control write
      if (shared_wr && ctrl.int_sel &&
          pin_f.data[`RTCIT_IR_PER_HI:0] == `RTCIT_PER_NONE) begin
        ctrl.int_halt <= 1'b1;
      end else if (timeout && !ireg[`RTCIT_IR_REPEAT]) begin
        ctrl.int_halt <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock setting register
  // ----------------------------------------------------------------
  // Mode bit; written only when the clock setting register is selected
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      hour_mode_24 <= 1'b0;
    end else if (shared_wr && !ctrl.int_sel) begin
      hour_mode_24 <= pin_f.data[`RTCIT_CS_MODE24];
    end
  end

  // AM/PM: toggles at noon in 12-hour mode, forced low in 24-hour.
  // It obeys the mode already in force, so a write that also flips
  // the mode does not set AM/PM as intended.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ampm <= 1'b0;
    end else if (hour_mode_24) begin
      ampm <= 1'b0;
    end else if (shared_wr && !ctrl.int_sel) begin
      ampm <= pin_f.data[`RTCIT_CS_AMPM];
    end else if (noon_roll) begin
      ampm <= ~ampm;
    end
  end

  // Leap year counter, two-bit binary, zero marks a leap year
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      leap <= 2'h0;
    end else if (shared_wr && !ctrl.int_sel) begin
      leap <= pin_f.data[`RTCIT_CS_LEAP_HI:`RTCIT_CS_LEAP_LO];
    end else if (year_roll) begin
      leap <= leap + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ireg <= `RTCIT_IREG_RESET;
    end else if (shared_wr && ctrl.int_sel) begin
      ireg <= pin_f.data;
    end
  end

  // Period code to tick count
  always_comb begin
    case (ireg[`RTCIT_IR_PER_HI:0])
      3'h1:    tmr_limit = `RTCIT_TICKS_0P1;
      3'h2:    tmr_limit = `RTCIT_TICKS_0P5;
      3'h3:    tmr_limit = `RTCIT_TICKS_1;
      3'h4:    tmr_limit = `RTCIT_TICKS_5;
      3'h5:    tmr_limit = `RTCIT_TICKS_10;
      3'h6:    tmr_limit = `RTCIT_TICKS_30;
      3'h7:    tmr_limit = `RTCIT_TICKS_60;
      default: tmr_limit = 10'h000; // No interrupt
    endcase
  end

  // ----------------------------------------------------------------
  // Setting tick divider
  // ----------------------------------------------------------------
  // Held at zero while the clock is halted, so restart gives a full
  // 100 ms; the interrupt timer shares this tick and halts with it
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      div_cnt <= 32'h0;
      tick    <= 1'b0;
    end else if (ctrl.clk_halt) begin
      div_cnt <= 32'h0;
      tick    <= 1'b0;
    end else if (div_cnt == 32'(TICK_CYCLES - 1)) begin
      div_cnt <= 32'h0;
      tick    <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 32'h1;
      tick    <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt timer
  // ----------------------------------------------------------------
  // Counter restarts exactly at expiry, so repeats never drift.
  // Selection of address 15 plays no part here.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      tmr_cnt <= 10'h0;
      timeout <= 1'b0;
    end else if (ctrl.int_halt || tmr_limit == 10'h000) begin
      tmr_cnt <= 10'h0;
      timeout <= 1'b0;
    end else if (tick && tmr_cnt == tmr_limit - 10'h1) begin
      tmr_cnt <= 10'h0;
      timeout <= 1'b1;
    end else if (tick) begin
      tmr_cnt <= tmr_cnt + 10'h1;
      timeout <= 1'b0;
    end else begin
      timeout <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Expiry seen during a control read waits for the read to end
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      to_pend <= 1'b0;
    end else if (timeout && ctrl_rd && !ctrl_rd_end) begin
      to_pend <= 1'b1;
    end else if (!ctrl_rd) begin
      to_pend <= 1'b0;
    end
  end

  // Data-changed flag; a set in the clearing cycle wins
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      dcf <= 1'b0;
    end else if (tick && !(ctrl_rd && !ctrl_rd_end)) begin
      dcf <= 1'b1;
    end else if (ctrl_rd_end) begin
      dcf <= 1'b0;
    end
  end

  // Interrupt flag; stays frozen through a control read
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      int_flag <= 1'b0;
    end else if (ctrl_rd_end) begin
      int_flag <= to_pend || timeout;
    end else if (timeout && !ctrl_rd) begin
      int_flag <= 1'b1;
    end
  end

  // Interrupt output request, also cleared by programming period zero
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      irq_act <= 1'b0;
    end else if (ctrl_rd_end) begin
      irq_act <= to_pend || timeout;
    end else if (timeout && !ctrl_rd) begin
      irq_act <= 1'b1;
    end else if (shared_wr && ctrl.int_sel &&
                 pin_f.data[`RTCIT_IR_PER_HI:0] == `RTCIT_PER_NONE) begin
      irq_act <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read data path
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = 4'h0;
    if ((phase == RTCIT_IDLE ? pin_f.addr : acc_addr) ==
        `RTCIT_ADDR_CTRL) begin
      next_rdata[`RTCIT_CR_DCF]      = dcf;
      next_rdata[`RTCIT_CR_INT_FLAG] = int_flag;
    end
    if ((phase == RTCIT_IDLE ? pin_f.addr : acc_addr) ==
        `RTCIT_ADDR_SHARED) begin
      if (ctrl.int_sel) begin
        next_rdata = ireg;
      end else begin
        next_rdata = {leap, ampm, hour_mode_24};
      end
    end
  end

  // Data captured before the read starts and held through it
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      data_out <= 4'h0;
      data_oe  <= 1'b0;
    end else begin
      if (phase != RTCIT_READ) begin
        data_out <= next_rdata;
      end
      data_oe <= (next_phase == RTCIT_READ);
    end
  end

  // ----------------------------------------------------------------
  // Interrupt pin and side outputs
  // ----------------------------------------------------------------
  // Test mode with no period programmed drives a square wave out
  // actively; otherwise the pin is open drain, low when asserted
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      osc_toggle <= 1'b0;
      irq_out    <= 1'b0;
      irq_oe     <= 1'b0;
    end else begin
      osc_toggle <= ~osc_toggle;
      if (ctrl.test && tmr_limit == 10'h000) begin
        irq_out <= osc_toggle;
        irq_oe  <= 1'b1;
      end else begin
        irq_out <= 1'b0;
        irq_oe  <= irq_act;
      end
    end
  end

  // Tick and control levels towards the time counters
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      setting_tick <= 1'b0;
      tenths_clear <= 1'b0;
      test_mode    <= 1'b0;
    end else begin
      setting_tick <= tick;
      tenths_clear <= ctrl.clk_halt;
      test_mode    <= ctrl.test;
    end
  end

endmodule : rtcit_core

/* tb/rtcit_core_asserts.sv */
// Assertion checker for the clock control and interrupt timer
`timescale 1ns/10ps
module rtcit_core_asserts
  import rtcit_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 20
) (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire rtcit_pins_t pins,
  input wire logic        year_roll,
  input wire logic        noon_roll,
  input wire logic [3:0]  data_out,
  input wire logic        data_oe,
  input wire logic        irq_out,
  input wire logic        irq_oe,
  input wire logic        setting_tick,
  input wire logic        tenths_clear,
  input wire logic        test_mode,
  input wire logic        hour_mode_24
);
  // ----------------------------------------------------------------
  // Tick spacing helper
  // ----------------------------------------------------------------
  logic [31:0] gap;   // Cycles since the last tick
  logic        seen;  // A tick seen since the last halt

  // Halt zeroes the divider, so spacing is judged only between ticks
  always_ff @(posedge ref_clk) begin
    if (!reset_n || tenths_clear) begin
      gap  <= '0;
      seen <= 1'b0;
    end else if (setting_tick) begin
      gap  <= '0;
      seen <= 1'b1;
    end else begin
      gap <= gap + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  property p_tick_gap;
    setting_tick && seen |-> gap + 32'h1 == TICK_CYCLES;
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("setting tick spacing wrong");

  property p_halt_tick;
    tenths_clear && $past(tenths_clear) |-> !setting_tick;
  endproperty
  a_halt_tick: assert property (p_halt_tick)
    else $error("tick while clock halted");

  property p_oe_stable;
    data_oe && $past(data_oe) |-> $stable(data_out);
  endproperty
  a_oe_stable: assert property (p_oe_stable)
    else $error("read data moved during read");

  property p_rd_clear;
    $fell(data_oe) && pins.addr == 4'h0 |-> ##[0:1] !irq_oe;
  endproperty
  a_rd_clear: assert property (p_rd_clear)
    else $error("control read left irq asserted");

  property p_no_rise_in_read;
    data_oe [*3] ##0 pins.addr == 4'h0 |-> !$rose(irq_oe);
  endproperty
  a_no_rise_in_read: assert property (p_no_rise_in_read)
    else $error("irq asserted inside control read");

  // Timeouts come only from ticks or from a deferred read-time timeout
  property p_irq_cause;
    $rose(irq_oe) && !test_mode && !$past(test_mode) |->
      $past(setting_tick, 2) || $past(setting_tick, 3) ||
      $past(setting_tick, 4) || $past(data_oe) || $past(data_oe, 2) ||
      $past(data_oe, 3) || $past(data_oe, 4);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("irq without timer timeout");

  property p_od_level;
    !test_mode && !$past(test_mode) |-> !irq_out;
  endproperty
  a_od_level: assert property (p_od_level)
    else $error("irq pin driven high outside test mode");

  property p_mode_write;
    $changed(hour_mode_24) |->
      pins.addr == 4'hf && hour_mode_24 == pins.data[0];
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("hour mode changed without its write");

  property p_test_write;
    $changed(test_mode) |-> pins.addr == 4'h0 && test_mode == pins.data[3];
  endproperty
  a_test_write: assert property (p_test_write)
    else $error("test latch changed without control write");

  property p_halt_write;
    $changed(tenths_clear) |->
      pins.addr == 4'h0 && tenths_clear == pins.data[2];
  endproperty
  a_halt_write: assert property (p_halt_write)
    else $error("clock halt changed without control write");

  property p_oe_strobe;
    $rose(data_oe) |-> !pins.cs_n && !pins.rd_n;
  endproperty
  a_oe_strobe: assert property (p_oe_strobe)
    else $error("read data driven without read strobe");
endmodule : rtcit_core_asserts

/* tb/rtcit_cpu_model.sv */
// Processor-side bus master model with a pulled-up interrupt line
`timescale 1ns/10ps
module rtcit_cpu_model
  import rtcit_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic [3:0] data_out,
  input  wire logic       data_oe,
  input  wire logic       irq_out,
  input  wire logic       irq_oe,
  output rtcit_pins_t     pins,
  output logic            irq_n
);
  logic       cs_n = 1'b1;  // Chip select
  logic       rd_n = 1'b1;  // Read strobe
  logic       wr_n = 1'b1;  // Write strobe
  logic       drv  = 1'b0;  // Processor drives the data lines
  logic [3:0] addr = 4'h0;  // Held address
  logic [3:0] wdat = 4'h0;  // Write data

  // Released data lines show inverted garbage, never the last value
  assign pins  = {cs_n, rd_n, wr_n, addr,
                  data_oe ? data_out : (drv ? wdat : ~wdat)};
  // Open-drain line with pull-up
  assign irq_n = irq_oe ? irq_out : 1'b1;

  // Data held well past the strobe, since commit uses filtered data
  task automatic bus_write(input logic [3:0] a, input logic [3:0] d);
    @(negedge ref_clk);
    addr = a;
    wdat = d;
    drv  = 1'b1;
    cs_n = 1'b0;
    wr_n = 1'b0;
    repeat (8) @(negedge ref_clk);
    cs_n = 1'b1;
    wr_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    drv = 1'b0;
  endtask : bus_write

  // Strobe held until the answer stands, then idle gap
  task automatic bus_read(input logic [3:0] a, output logic [3:0] d);
    int n;
    @(negedge ref_clk);
    addr = a;
    cs_n = 1'b0;
    rd_n = 1'b0;
    n = 0;
    while (data_oe !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    repeat (2) @(negedge ref_clk);
    d = data_oe ? data_out : 4'hx;
    cs_n = 1'b1;
    rd_n = 1'b1;
    repeat (8) @(negedge ref_clk);
  endtask : bus_read
endmodule : rtcit_cpu_model

/* tb/tb_rtcit_core.sv */
// Self-checking testbench for the clock control and interrupt timer
`timescale 1ns/10ps
module tb_rtcit_core;
  import rtcit_pkg::*;
  localparam int unsigned TCK = 20;  // Short tick keeps the run brief
  localparam int LIMIT = 60000;      // Cycle ceiling for the whole run
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        year_roll = 1'b0;
  logic        noon_roll = 1'b0;
  rtcit_pins_t pins;
  logic [3:0]  data_out;
  logic        data_oe;
  logic        irq_out;
  logic        irq_oe;
  logic        irq_n;
  logic        setting_tick;
  logic        tenths_clear;
  logic        test_mode;
  logic        hour_mode_24;
  logic [3:0]  rd;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          n;
  int          t0;
  int          per [8] = '{0, 1, 5, 10, 50, 100, 300, 600}; // Ticks

  rtcit_core #(.TICK_CYCLES(TCK)) rtcit_core_inst (
    .ref_clk, .reset_n, .pins, .year_roll, .noon_roll, .data_out,
    .data_oe, .irq_out, .irq_oe, .setting_tick, .tenths_clear,
    .test_mode, .hour_mode_24
  );
  rtcit_cpu_model rtcit_cpu_model_inst (
    .ref_clk, .data_out, .data_oe, .irq_out, .irq_oe, .pins, .irq_n
  );

  // ----------------------------------------------------------------
  // Clock, hang guard and shared tasks
  // ----------------------------------------------------------------
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  // A hang counts as a failure
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      summarize();
    end
  end

  task automatic summarize();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [3:0] d);
    rtcit_cpu_model_inst.bus_write(a, d);
  endtask : wr

  task automatic rd_chk(input logic [3:0] a, input logic [3:0] e);
    rtcit_cpu_model_inst.bus_read(a, rd);
    check({12'h0, rd}, {12'h0, e});
  endtask : rd_chk

  task automatic pulse_roll(input logic year);
    @(negedge ref_clk);
    year_roll = year;
    noon_roll = !year;
    @(negedge ref_clk);
    year_roll = 1'b0;
    noon_roll = 1'b0;
  endtask : pulse_roll

  // Counts ticks until the pin goes low, bounded by lim cycles
  task automatic wait_irq(input int lim, output int t);
    int c;
    t = 0;
    c = 0;
    while (irq_n !== 1'b0 && c < lim) begin
      @(negedge ref_clk);
      c++;
      if (setting_tick === 1'b1) t++;
    end
  endtask : wait_irq

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    // Halted clock: no ticks, so the changed flag stays clear
    wr(4'h0, 4'h5);
    check(16'(tenths_clear), 16'h1);
    rtcit_cpu_model_inst.bus_read(4'h0, rd);
    rd_chk(4'h0, 4'h0);
    wr(4'h0, 4'h1);
    repeat (TCK + 4) @(negedge ref_clk);
    rd_chk(4'h7, 4'h0);
    rd_chk(4'hf, 4'h0);
    rd_chk(4'h0, 4'h8);
    // Clock setting fields and their roll-over behaviour
    wr(4'hf, 4'hc);
    wr(4'hf, 4'he);
    rd_chk(4'hf, 4'he);
    pulse_roll(1'b0);
    rd_chk(4'hf, 4'hc);
    pulse_roll(1'b1);
    rd_chk(4'hf, 4'h0);
    pulse_roll(1'b1);
    rd_chk(4'hf, 4'h4);
    wr(4'hf, 4'h5);
    check(16'(hour_mode_24), 16'h1);
    wr(4'hf, 4'h7);
    pulse_roll(1'b0);
    rd_chk(4'hf, 4'h5);
    // Test latch in and out
    wr(4'h0, 4'h9);
    check(16'(test_mode), 16'h1);
    wr(4'h0, 4'h1);
    check(16'(test_mode), 16'h0);
    // Shared address selection
    wr(4'h0, 4'h3);
    wr(4'hf, 4'hb);
    rd_chk(4'hf, 4'hb);
    wr(4'h0, 4'h1);
    rd_chk(4'hf, 4'h5);
    // Every nonzero period code in single mode
    for (int k = 1; k < 8; k++) begin
      wr(4'h0, 4'h3);
      wr(4'hf, {1'b0, 3'(k)});
      wr(4'h0, 4'h2);
      wait_irq(per[k] * TCK + 4 * TCK, n);
      check(16'(n >= per[k] - 1 && n <= per[k]), 16'h1);
      rtcit_cpu_model_inst.bus_read(4'h0, rd);
      check(16'(rd[0]), 16'h1);
      check(16'(irq_n), 16'h1);
      if (k == 1) begin
        wait_irq(3 * TCK, n);
        check(16'(irq_n), 16'h1);
      end
    end
    // Repeated mode keeps exact spacing across control reads
    wr(4'h0, 4'h3);
    wr(4'hf, 4'ha);
    wr(4'h0, 4'h2);
    wait_irq(8 * TCK, n);
    for (int j = 0; j < 2; j++) begin
      t0 = cycles;
      rtcit_cpu_model_inst.bus_read(4'h0, rd);
      wait_irq(8 * TCK, n);
      check(16'(cycles - t0), 16'(5 * TCK));
    end
    // A timeout inside a control read waits for the read to end
    rtcit_cpu_model_inst.bus_read(4'h0, rd);
    repeat (5 * TCK - 28) @(negedge ref_clk);
    rtcit_cpu_model_inst.bus_read(4'h0, rd);
    check(16'(rd[0]), 16'h0);
    check(16'(irq_n), 16'h0);
    // Period zero stops the interrupt timer until the halt latch is cleared
    wr(4'hf, 4'h0);
    check(16'(irq_n), 16'h1);
    wr(4'hf, 4'ha);
    wait_irq(10 * TCK, n);
    check(16'(irq_n), 16'h1);
    wr(4'h0, 4'h2);
    wait_irq(8 * TCK, n);
    check(16'(n >= 4 && n <= 5), 16'h1);
    summarize();
  end
endmodule : tb_rtcit_core

bind rtcit_core rtcit_core_asserts #(.TICK_CYCLES(TICK_CYCLES))
  rtcit_core_asserts_inst (
    .ref_clk, .reset_n, .pins, .year_roll, .noon_roll, .data_out,
    .data_oe, .irq_out, .irq_oe, .setting_tick, .tenths_clear,
    .test_mode, .hour_mode_24
  );
